// file: core/class_d_audio_modulator.sv
// Class D audio modulator: register port, sample FIFO, hold, CIC, modulator, driver legs
module class_d_audio_modulator #(
  parameter int MOD_TICK_DIV = 4
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  input  wire logic [class_d_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [class_d_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [class_d_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                          i_mod_clk_double,
  output logic                               o_dma_req,
  output logic                               o_speaker_out_positive,
  output logic                               o_speaker_out_positive_oe_n,
  output logic                               o_speaker_out_negative,
  output logic                               o_speaker_out_negative_oe_n,
  output logic      [1:0]                    o_gate_high,
  output logic      [1:0]                    o_gate_low
);
  localparam int PTR_W = $clog2(class_d_pkg::FIFO_DEPTH);
  localparam int PH_W  = $clog2(class_d_pkg::UPSAMPLE);
  localparam int MD_W  = $clog2(MOD_TICK_DIV + 1);

  initial begin
    if (MOD_TICK_DIV < 2 || (MOD_TICK_DIV % 2) != 0) begin
      $error("MOD_TICK_DIV must be even and at least 2");
    end
  end

  // Register bus
  class_d_pkg::control_s                 ctrl_r, ctrl_nxt;
  logic                                  dma_en_r, dma_en_nxt;
  logic [class_d_pkg::HOLD_W-1:0]        div_r, div_nxt;
  logic [class_d_pkg::DATA_W-1:0]        rdata_nxt;
  class_d_pkg::fifo_flags_s              flags;
  logic                                  push;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    dma_en_nxt = dma_en_r;
    div_nxt    = div_r;
    rdata_nxt  = '0;
    push       = 1'b0;
    if (i_wr) begin
      unique case (i_addr)
        class_d_pkg::OFF_CONTROL:  ctrl_nxt = i_wdata[class_d_pkg::BIT_ENABLE:0];
        class_d_pkg::OFF_DMA:      dma_en_nxt = i_wdata[class_d_pkg::BIT_DMA_EN];
        class_d_pkg::OFF_FIFO_IN:  push = 1'b1;
        class_d_pkg::OFF_HOLD_DIV: begin
          if (i_wdata[class_d_pkg::HOLD_W-1:0] != '0) begin
            div_nxt = i_wdata[class_d_pkg::HOLD_W-1:0];
          end
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        class_d_pkg::OFF_CONTROL:  rdata_nxt = {25'h0, ctrl_r};
        class_d_pkg::OFF_STATUS:   rdata_nxt = {30'h0, flags};
        class_d_pkg::OFF_DMA:      rdata_nxt = {31'h0, dma_en_r};
        class_d_pkg::OFF_HOLD_DIV: rdata_nxt = {24'h0, div_r};
        default:                   rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_r   <= '0;
      dma_en_r <= 1'b0;
      div_r    <= class_d_pkg::HOLD_DIV_RST;
      o_rdata  <= '0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      dma_en_r <= dma_en_nxt;
      div_r    <= div_nxt;
      o_rdata  <= rdata_nxt;
    end
  end

  // Sample FIFO and hold timing
  logic [class_d_pkg::SAMPLE_W-1:0] mem_r [class_d_pkg::FIFO_DEPTH];
  logic [class_d_pkg::SAMPLE_W-1:0] mem_nxt [class_d_pkg::FIFO_DEPTH];
  logic [PTR_W:0]                   wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic                             en_prev_r;
  logic [class_d_pkg::HOLD_W-1:0]   hcnt_r, hcnt_nxt;
  logic [PH_W-1:0]                  phase_r, phase_nxt;
  logic [class_d_pkg::SAMPLE_W-1:0] held_r, held_nxt;
  logic                             tick, pop;

  assign flags.full  = (wptr_r[PTR_W] != rptr_r[PTR_W]) &&
                       (wptr_r[PTR_W-1:0] == rptr_r[PTR_W-1:0]);
  assign flags.empty = (wptr_r == rptr_r);
  assign o_dma_req   = dma_en_r && !flags.full;

  // Each hold tick is one CIC output step; every 64th takes a sample
  assign tick = ctrl_r.enable && (hcnt_r == div_r - 8'h01);
  assign pop  = tick && (phase_r == '0);

  always_comb begin
    mem_nxt   = mem_r;
    wptr_nxt  = wptr_r;
    rptr_nxt  = rptr_r;
    held_nxt  = held_r;
    hcnt_nxt  = tick ? '0 : hcnt_r + 8'h01;
    phase_nxt = tick ? phase_r + 1'b1 : phase_r;
    if (push && !flags.full) begin
      mem_nxt[wptr_r[PTR_W-1:0]] = i_wdata[class_d_pkg::SAMPLE_W-1:0];
      wptr_nxt = wptr_r + 1'b1;
    end
    if (pop && !flags.empty) begin
      held_nxt = mem_r[rptr_r[PTR_W-1:0]];
      rptr_nxt = rptr_r + 1'b1;
    end
    if (!ctrl_r.enable) begin
      hcnt_nxt  = '0;
      phase_nxt = '0;
      if (en_prev_r) begin
        wptr_nxt = '0;
        rptr_nxt = '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wptr_r    <= '0;
      rptr_r    <= '0;
      en_prev_r <= 1'b0;
      hcnt_r    <= '0;
      phase_r   <= '0;
      held_r    <= '0;
    end else begin
      wptr_r    <= wptr_nxt;
      rptr_r    <= rptr_nxt;
      en_prev_r <= ctrl_r.enable;
      hcnt_r    <= hcnt_nxt;
      phase_r   <= phase_nxt;
      held_r    <= held_nxt;
    end
    mem_r <= mem_nxt;
  end

  // Two-stage CIC interpolator: combs at sample rate, integrators at hold rate
  logic signed [class_d_pkg::CIC_W-1:0] x_d_r, c1_d_r, i1_r, i2_r;
  logic signed [class_d_pkg::CIC_W-1:0] x_d_nxt, c1_d_nxt, i1_nxt, i2_nxt;
  logic signed [class_d_pkg::CIC_W-1:0] x_in, c1, c2;
  logic        [class_d_pkg::SAMPLE_W-1:0] cic_out;

  always_comb begin
    x_in     = class_d_pkg::CIC_W'($signed(held_nxt));
    c1       = x_in - x_d_r;
    c2       = c1 - c1_d_r;
    x_d_nxt  = x_d_r;
    c1_d_nxt = c1_d_r;
    i1_nxt   = i1_r;
    i2_nxt   = i2_r;
    if (tick) begin
      i1_nxt = i1_r + (pop ? c2 : '0);
      i2_nxt = i2_r + i1_nxt;
      if (pop) begin
        x_d_nxt  = x_in;
        c1_d_nxt = c1;
      end
    end
    if (!ctrl_r.enable) begin
      x_d_nxt  = '0;
      c1_d_nxt = '0;
      i1_nxt   = '0;
      i2_nxt   = '0;
    end
  end

  assign cic_out = i2_r[class_d_pkg::CIC_SHIFT +: class_d_pkg::SAMPLE_W];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      x_d_r  <= '0;
      c1_d_r <= '0;
      i1_r   <= '0;
      i2_r   <= '0;
    end else begin
      x_d_r  <= x_d_nxt;
      c1_d_r <= c1_d_nxt;
      i1_r   <= i1_nxt;
      i2_r   <= i2_nxt;
    end
  end

  // Modulator: enable pulse stands in for the modulator clock
  function automatic logic signed [class_d_pkg::DUTY_W-1:0] dither_amount(
    input logic [1:0] sel,
    input logic       coin
  );
    logic signed [class_d_pkg::DUTY_W-1:0] mag;
    mag = '0;
    unique case (sel)
      class_d_pkg::DITH_ONE: mag = 12'sd1;
      class_d_pkg::DITH_TWO: mag = 12'sd2;
      default:               mag = '0;
    endcase
    return coin ? -mag : mag;
  endfunction

  logic [MD_W-1:0]                    mdiv_r, mdiv_nxt;
  logic [MD_W-1:0]                    mdiv_last;
  logic                               mtick;
  logic [class_d_pkg::CAR_W-1:0]      car_div, ccnt_r, ccnt_nxt;
  logic [class_d_pkg::DUTY_W-1:0]     duty_r, duty_nxt;
  logic [15:0]                        err_r, err_nxt;
  logic [class_d_pkg::LFSR_W-1:0]     lfsr_r, lfsr_nxt;
  logic [26:0]                        q;
  logic signed [class_d_pkg::DUTY_W-1:0] dq;
  logic                               pwm_r, pwm_nxt;

  assign mdiv_last = i_mod_clk_double ? MD_W'(MOD_TICK_DIV / 2 - 1)
                                      : MD_W'(MOD_TICK_DIV - 1);
  assign mtick     = (mdiv_r == mdiv_last);
  assign car_div   = class_d_pkg::CAR_DIV[ctrl_r.carrier_sel];

  always_comb begin
    mdiv_nxt = mtick ? '0 : mdiv_r + 1'b1;
    ccnt_nxt = ccnt_r;
    duty_nxt = duty_r;
    err_nxt  = err_r;
    lfsr_nxt = lfsr_r;
    pwm_nxt  = pwm_r;
    q  = 27'((cic_out ^ class_d_pkg::SIGN_FLIP) * car_div) + 27'(err_r);
    dq = $signed({1'b0, q[26:16]}) + dither_amount(ctrl_r.dither, lfsr_r[0]);
    if (mtick) begin
      pwm_nxt = (12'(ccnt_r) < duty_r);
      if (ccnt_r >= car_div - 10'd1) begin
        ccnt_nxt = '0;
        err_nxt  = q[15:0];
        lfsr_nxt = lfsr_r[0] ? (lfsr_r >> 1) ^ class_d_pkg::LFSR_TAPS : lfsr_r >> 1;
        if (dq < 0) begin
          duty_nxt = '0;
        end else if (dq > $signed({2'b00, car_div})) begin
          duty_nxt = 12'(car_div);
        end else begin
          duty_nxt = dq;
        end
      end else begin
        ccnt_nxt = ccnt_r + 10'd1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mdiv_r <= '0;
      ccnt_r <= '0;
      duty_r <= '0;
      err_r  <= '0;
      lfsr_r <= class_d_pkg::LFSR_SEED;
      pwm_r  <= 1'b0;
    end else begin
      mdiv_r <= mdiv_nxt;
      ccnt_r <= ccnt_nxt;
      duty_r <= duty_nxt;
      err_r  <= err_nxt;
      lfsr_r <= lfsr_nxt;
      pwm_r  <= pwm_nxt;
    end
  end

  // Driver legs: 0 positive, 1 negative, both gates off during a switch gap
  logic [1:0] leg_r, leg_nxt, target;
  logic [1:0] gap_r [2];
  logic [1:0] gap_nxt [2];
  logic [1:0] gap_len;

  assign target  = {~pwm_r, pwm_r};
  assign gap_len = ctrl_r.deadtime ? 2'd2 : 2'd1;

  always_comb begin
    leg_nxt = leg_r;
    gap_nxt = gap_r;
    for (int k = 0; k < 2; k++) begin
      if (mtick) begin
        if (gap_r[k] != '0) begin
          gap_nxt[k] = gap_r[k] - 2'd1;
          if (gap_r[k] == 2'd1) begin
            leg_nxt[k] = target[k];
          end
        end else if (target[k] != leg_r[k]) begin
          gap_nxt[k] = gap_len;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      leg_r <= 2'b10;
      gap_r <= '{2'd0, 2'd0};
    end else begin
      leg_r <= leg_nxt;
      gap_r <= gap_nxt;
    end
  end

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      o_gate_high[k] = ctrl_r.enable && leg_r[k] && (gap_r[k] == '0);
      o_gate_low[k]  = ctrl_r.enable && !leg_r[k] && (gap_r[k] == '0);
    end
  end

  assign o_speaker_out_positive      = leg_r[0];
  assign o_speaker_out_negative      = leg_r[1];
  assign o_speaker_out_positive_oe_n = !ctrl_r.enable;
  assign o_speaker_out_negative_oe_n = !ctrl_r.enable;
endmodule

// file: core/class_d_pkg.sv
// Constants, register map and field layouts of the class D audio modulator
package class_d_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          SAMPLE_W      = 16;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          HOLD_W        = 8;
  localparam int          UPSAMPLE      = 64;
  localparam int          CIC_W         = 32;
  localparam int          CIC_SHIFT     = 6;
  localparam int          CAR_W         = 10;
  localparam int          DUTY_W        = 12;
  localparam int          LFSR_W        = 16;

  localparam logic [7:0]  OFF_CONTROL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_DMA       = 8'h08;
  localparam logic [7:0]  OFF_FIFO_IN   = 8'h0C;
  localparam logic [7:0]  OFF_HOLD_DIV  = 8'h10;

  localparam int          BIT_ENABLE    = 6;
  localparam int          BIT_DITH_HI   = 5;
  localparam int          BIT_DITH_LO   = 4;
  localparam int          BIT_DEADTIME  = 3;
  localparam int          BIT_CAR_HI    = 2;
  localparam int          BIT_EMPTY     = 1;
  localparam int          BIT_FULL      = 0;
  localparam int          BIT_DMA_EN    = 0;

  localparam logic [7:0]  HOLD_DIV_RST  = 8'h30;
  localparam logic [31:0] STATUS_RST    = 32'h0000_0002;
  localparam logic [15:0] SIGN_FLIP     = 16'h8000;
  localparam logic [15:0] LFSR_SEED     = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS     = 16'hB400;

  localparam logic [1:0]  DITH_NONE     = 2'h0;
  localparam logic [1:0]  DITH_ONE      = 2'h1;
  localparam logic [1:0]  DITH_TWO      = 2'h3;

  localparam logic [9:0]  CAR_DIV [8]   = '{10'd228, 10'd156, 10'd76, 10'd52,
                                            10'd780, 10'd524, 10'd396, 10'd268};

  typedef struct packed {
    logic       enable;
    logic [1:0] dither;
    logic       deadtime;
    logic [2:0] carrier_sel;
  } control_s;

  typedef struct packed {
    logic       empty;
    logic       full;
  } fifo_flags_s;
endpackage

// file: tb/class_d_audio_modulator_tb_top.sv
// Self-checking bench of the class D audio modulator
module class_d_audio_modulator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_srst = 1'b1, tb_wr = 1'b0, tb_rd = 1'b0, dbl = 1'b0, go = 1'b0;
  logic [7:0]  tb_addr = 8'h00, p_addr, p_count;
  logic [31:0] tb_wdata = 32'h0, p_wdata, o_rdata;
  logic [3:0]  gap = 4'h0;
  logic        p_wr, o_dma_req, pos, pos_oe_n, neg, neg_oe_n;
  logic [1:0]  gh, gl;
  int          miscompares = 0, checks = 0;
  always #2 i_clk = ~i_clk;
  class_d_audio_modulator #(.MOD_TICK_DIV(2)) u_dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(p_wr ? p_addr : tb_addr), .i_wdata(p_wr ? p_wdata : tb_wdata),
    .i_wr(tb_wr | p_wr), .i_rd(tb_rd), .o_rdata(o_rdata), .i_mod_clk_double(dbl),
    .o_dma_req(o_dma_req), .o_speaker_out_positive(pos), .o_speaker_out_positive_oe_n(pos_oe_n),
    .o_speaker_out_negative(neg), .o_speaker_out_negative_oe_n(neg_oe_n),
    .o_gate_high(gh), .o_gate_low(gl));
  dma_sample_feeder u_dma (.i_clk(i_clk), .i_srst(i_srst), .i_go(go), .i_req(o_dma_req),
    .i_gap(gap), .o_wr(p_wr), .o_addr(p_addr), .o_wdata(p_wdata), .o_count(p_count));
  task automatic end_of_test;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tb_wr <= 1'b1;
    tb_addr <= a;
    tb_wdata <= d;
    @(posedge i_clk);
    tb_wr <= 1'b0;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Carrier period in clock cycles, between two rising edges of the positive leg
  task automatic period_chk(input int exp);
    time t0;
    @(posedge pos);
    t0 = $time;
    @(posedge pos);
    chk(32'(($time - t0) / 4), 32'(exp));
  endtask
  // Cycles with both gates of the positive leg off during a high-to-low switch
  task automatic gap_chk(input int exp);
    int n;
    n = 0;
    @(negedge i_clk iff gh[0] == 1'b1);
    @(negedge i_clk iff gh[0] == 1'b0);
    while (gl[0] == 1'b0) begin
      n++;
      @(negedge i_clk);
    end
    chk(32'(n), 32'(exp));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    tb_rd <= 1'b1;
    tb_addr <= a;
    @(posedge i_clk);
    tb_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic t_reset_values;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h2);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h10, 32'h30);
    rd_chk(8'h14, 32'h0);
  endtask
  task automatic t_registers;
    wr(8'h10, 32'h0);
    rd_chk(8'h10, 32'h30);
    wr(8'h10, 32'h5);
    rd_chk(8'h10, 32'h5);
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h2);
    wr(8'h00, 32'h3B);
    rd_chk(8'h00, 32'h3B);
  endtask
  task automatic t_fill;
    chk({31'h0, o_dma_req}, 32'h0);
    wr(8'h08, 32'h1);
    chk({31'h0, o_dma_req}, 32'h1);
    go <= 1'b1;
    for (int i = 0; i < 200 && (o_dma_req !== 1'b0 || i < 3); i++) @(posedge i_clk);
    go <= 1'b0;
    cyc(2);
    chk({24'h0, p_count}, 32'h10);
    rd_chk(8'h04, 32'h1);
    wr(8'h0C, 32'h1234);
    rd_chk(8'h04, 32'h1);
  endtask
  task automatic t_stream;
    gap <= 4'h3;
    go <= 1'b1;
    wr(8'h00, 32'h40);
    cyc(5 * 64 * 4);
    go <= 1'b0;
    cyc(2);
    chk({31'h0, p_count >= 8'h13 && p_count <= 8'h15}, 32'h1);
    chk({30'h0, pos_oe_n, neg_oe_n}, 32'h0);
  endtask
  task automatic t_modes;
    logic [1:0] dith [3] = '{2'h0, 2'h1, 2'h3};
    for (int s = 0; s < 8; s++) begin
      dbl <= s[0];
      wr(8'h00, {25'h0, 1'b1, dith[s % 3], s[1], s[2:0]});
      cyc(900);
      chk({31'h0, pos !== neg}, 32'h1);
      period_chk(class_d_pkg::CAR_DIV[s] * (s[0] ? 1 : 2));
      gap_chk((1 + s[1]) * (s[0] ? 1 : 2));
      cyc(1);
    end
    wr(8'h00, 32'h0);
    cyc(2);
    chk({30'h0, pos_oe_n, neg_oe_n}, 32'h3);
    rd_chk(8'h04, 32'h2);
    chk({31'h0, o_dma_req}, 32'h1);
    wr(8'h08, 32'h0);
    chk({31'h0, o_dma_req}, 32'h0);
    cyc(2);
    chk({31'h0, o_dma_req}, 32'h0);
  endtask
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    t_reset_values;
    t_registers;
    t_fill;
    t_stream;
    t_modes;
    end_of_test;
  end
endmodule

// file: tb/class_d_properties.sv
// Port-level checker for the class D audio modulator
module class_d_properties (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_dma_req,
  input wire logic        o_speaker_out_positive,
  input wire logic        o_speaker_out_positive_oe_n,
  input wire logic        o_speaker_out_negative,
  input wire logic        o_speaker_out_negative_oe_n,
  input wire logic [1:0]  o_gate_high,
  input wire logic [1:0]  o_gate_low
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  oe_pair_a: assert property (o_speaker_out_positive_oe_n == o_speaker_out_negative_oe_n)
    else $error("leg enables differ");
  legs_opposite_a: assert property (!o_speaker_out_positive_oe_n |->
    o_speaker_out_positive != o_speaker_out_negative) else $error("legs in phase");
  gate_excl_a: assert property ((o_gate_high & o_gate_low) == 2'h0)
    else $error("both gates on");
  gates_off_a: assert property (o_speaker_out_positive_oe_n |->
    o_gate_high == 2'h0 && o_gate_low == 2'h0) else $error("gates on while disabled");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0) else $error("stale read data");
  status_shape_a: assert property (i_rd && i_addr == class_d_pkg::OFF_STATUS |=>
    o_rdata[31:2] == 30'h0) else $error("status high bits set");
  req_not_full_a: assert property (i_rd && i_addr == class_d_pkg::OFF_STATUS &&
    o_dma_req |=> !o_rdata[class_d_pkg::BIT_FULL]) else $error("request while full");
  fifo_wo_a: assert property (i_rd && i_addr == class_d_pkg::OFF_FIFO_IN |=>
    o_rdata == 32'h0) else $error("fifo input readable");
  dma_gate_a: assert property (i_wr && i_addr == class_d_pkg::OFF_DMA &&
    !i_wdata[0] |=> !o_dma_req [*2]) else $error("request while gated");
endmodule

bind class_d_audio_modulator class_d_properties u_props (.*);

// file: tb/dma_sample_feeder.sv
// Peripheral DMA channel model writing samples on request
module dma_sample_feeder (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_go,
  input  wire logic        i_req,
  input  wire logic [3:0]  i_gap,
  output logic             o_wr,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata,
  output logic [7:0]       o_count
);
  logic [3:0] wait_r;
  always @(posedge i_clk) begin
    if (i_srst || !i_go) begin
      o_wr    <= 1'b0;
      o_addr  <= 8'hFF;
      wait_r  <= 4'h0;
    end else if (o_wr) begin
      o_wr    <= 1'b0;
      o_addr  <= ~o_addr;
      o_wdata <= ~o_wdata;
      wait_r  <= i_gap;
    end else if (wait_r != 4'h0) begin
      wait_r  <= wait_r - 4'h1;
    end else if (i_req) begin
      o_wr    <= 1'b1;
      o_addr  <= class_d_pkg::OFF_FIFO_IN;
      o_wdata <= {16'hA5A5, 8'h10, o_count};
      o_count <= o_count + 8'h01;
    end
  end
  initial o_count = 8'h00;
  initial o_wdata = 32'h0;
endmodule
